// file: lcm_pkg.sv
// package: constants, types and register map of the logic cell block
package lcm_pkg;

  // bus register map (byte addresses)
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_LUT    = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_INFO   = 8'h0c;
  localparam int          ADDR_W      = 8;

  // field widths and reset values
  localparam int          CTRL_W      = 9;
  localparam int          LUT_W       = 16;
  localparam int          STATUS_W    = 6;
  localparam logic [8:0]  CTRL_RST    = 9'h000;
  localparam logic [15:0] LUT_RST     = 16'h0000;

  // extra cells spent per register on preset+clear or async-load emulation
  localparam logic [3:0]  EMUL_COST   = 4'h3;
  localparam int          EMUL_COST_W = 4;

  // sum / carry split of the lookup mask in arithmetic mode
  localparam logic        LUT_HALF_SUM   = 1'b0;
  localparam logic        LUT_HALF_CARRY = 1'b1;

  // ahb-lite encodings
  localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_ARITH  = 2'b01,
    MODE_COUNT  = 2'b10,
    MODE_SPARE  = 2'b11
  } lcm_mode_e;

  // control register, msb first; bit positions follow the declaration
  typedef struct packed {
    logic      emul;       // bit 8: preset+load emulated by inversion
    logic      clk_sel;    // bit 7: 0 group clock one, 1 group clock two
    logic      preset;     // bit 6: register loads 1 instead of 0 under chip reset
    logic      pack_en;    // bit 5: packed register
    logic      casc_or;    // bit 4: cascade joins by or instead of and
    logic      casc_en;    // bit 3: cascade chain in use
    logic      carry_sel;  // bit 2: carry-in replaces cell_input_c
    lcm_mode_e mode;       // bits 1:0
  } lcm_cfg_s;

  // pins of the cell after synchronisation
  typedef struct packed {
    logic chip_reset_n;
    logic async_clear;
    logic async_preset;
    logic sync_clear;
    logic sync_load;
    logic group_clock_one;
    logic group_clock_two;
    logic group_clock_enable_one;
    logic group_clock_enable_two;
    logic carry_in;
    logic cascade_in;
    logic cell_input_d;
    logic cell_input_c;
    logic cell_input_b;
    logic cell_input_a;
  } lcm_pins_s;

  localparam int PINS_W = 15;

endpackage

// file: lcm_logic_cell.sv
// logic cell with normal, arithmetic and counter modes behind an ahb-lite slave
//
// Notes on behaviour
// (R1) normal mode: four inputs into lookup function
// (R2) carry-in or cell_input_c, chosen by configuration
// (R3) lookup output combined with cascade-in onward
// (R4) cascade joins by and, or by or
// (R5) packed register: lookup and register drive separately
// (R6) carry-in used: no packed register
// (R7) arithmetic: first half gives sum-like result
// (R8) arithmetic: second half gives carry-out
// (R9) arithmetic mode keeps cascade chain usable
// (R10) registered and unregistered results both driven
// (R11) counter: enables, direction, sync clear, load
// (R12) counter enable and direction from data inputs
// (R13) group sync clear and load hit register
// (R14) user fills rest of group consistently
// (R15) count and carry halves, load mux, clear gate
// (R16) sync clear or load beats cascade value
// (R17) sync clear beats sync load
// (R18) group async clear and preset control register
// (R19) emulation costs three extra cells per register
// (R20) emulated preset+load register undefined after reset
// (R21) chip reset beats every other control
// (R22) preset registers preset under chip reset
// (R23) chip reset use fixed before build
// (R24) two clocks each paired with own enable
// (R25) counter steps by one, else holds
// (R26) sync controls on enabled edge, async immediately
`timescale 1ns/1ps

module lcm_logic_cell #(
  parameter bit CHIP_RESET_USED = 1'b1  // see (R23)
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        SYS_RST_I,
  // ahb-lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  // cell pins
  input  wire logic        CELL_INPUT_A_I,
  input  wire logic        CELL_INPUT_B_I,
  input  wire logic        CELL_INPUT_C_I,
  input  wire logic        CELL_INPUT_D_I,
  input  wire logic        CARRY_IN_I,
  input  wire logic        CASCADE_IN_I,
  input  wire logic        GROUP_CLOCK_ONE_I,
  input  wire logic        GROUP_CLOCK_TWO_I,
  input  wire logic        GROUP_CLOCK_ENABLE_ONE_I,
  input  wire logic        GROUP_CLOCK_ENABLE_TWO_I,
  input  wire logic        ASYNC_CLEAR_I,
  input  wire logic        ASYNC_PRESET_I,
  input  wire logic        SYNC_CLEAR_I,
  input  wire logic        SYNC_LOAD_I,
  input  wire logic        CHIP_RESET_N_I,
  output logic             COMB_O,
  output logic             REG_O,
  output logic             CARRY_O,
  output logic             CASCADE_O,
  output logic             UNDEFINED_O
);

  function automatic logic lut_pick(input logic [15:0] mask, input logic [3:0] idx);
    lut_pick = mask[idx];
  endfunction

  function automatic logic casc_join(input logic val, input logic cin, input logic use_or);
    // or form is the and gate with inverted inputs and output
    casc_join = use_or ? ~(~val & ~cin) : (val & cin);
  endfunction

  // two-flop synchronisers for every pin of the cell
  lcm_pkg::lcm_pins_s pins_raw;
  lcm_pkg::lcm_pins_s sync1_reg;
  lcm_pkg::lcm_pins_s pin;

  assign pins_raw = '{chip_reset_n:           CHIP_RESET_N_I,
                      async_clear:            ASYNC_CLEAR_I,
                      async_preset:           ASYNC_PRESET_I,
                      sync_clear:             SYNC_CLEAR_I,
                      sync_load:              SYNC_LOAD_I,
                      group_clock_one:        GROUP_CLOCK_ONE_I,
                      group_clock_two:        GROUP_CLOCK_TWO_I,
                      group_clock_enable_one: GROUP_CLOCK_ENABLE_ONE_I,
                      group_clock_enable_two: GROUP_CLOCK_ENABLE_TWO_I,
                      carry_in:               CARRY_IN_I,
                      cascade_in:             CASCADE_IN_I,
                      cell_input_d:           CELL_INPUT_D_I,
                      cell_input_c:           CELL_INPUT_C_I,
                      cell_input_b:           CELL_INPUT_B_I,
                      cell_input_a:           CELL_INPUT_A_I};

  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      // chip reset pin idles high
      sync1_reg <= '{chip_reset_n: 1'b1, default: 1'b0};
      pin       <= '{chip_reset_n: 1'b1, default: 1'b0};
    end
    else
    begin
      sync1_reg <= pins_raw;
      pin       <= sync1_reg;
    end
  end

  // group clocks become one-cycle ticks on their rising edge
  logic group_clock_one_last_reg;
  logic clk2_last_reg;

  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      group_clock_one_last_reg <= 1'b0;
      clk2_last_reg <= 1'b0;
    end
    else
    begin
      group_clock_one_last_reg <= pin.group_clock_one;
      clk2_last_reg <= pin.group_clock_two;
    end
  end

  // configuration registers
  lcm_pkg::lcm_cfg_s cfg_reg;
  logic [15:0]       lut_reg;

  // each clock only ever pairs with its own enable
  logic tick;
  logic tick_en;
  assign tick    = cfg_reg.clk_sel ? (pin.group_clock_two & ~clk2_last_reg)
                                   : (pin.group_clock_one & ~group_clock_one_last_reg);   // see (R24)
  assign tick_en = tick & (cfg_reg.clk_sel ? pin.group_clock_enable_two
                                           : pin.group_clock_enable_one);     // see (R24)

  // ahb-lite slave: zero wait states, always okay
  logic                      wr_pend_reg;
  logic [lcm_pkg::ADDR_W-1:0] wr_addr_reg;
  logic                      addr_take;
  logic [lcm_pkg::ADDR_W-1:0] addr_lo;
  logic [31:0]               rd_next;

  assign addr_take = HSEL_I & HREADY_I & HTRANS_I[1];
  assign addr_lo   = HADDR_I[lcm_pkg::ADDR_W-1:0];

  // cell state
  logic      cell_q_reg;
  logic      undef_reg;
  logic      chip_rst_act;
  logic      force_act;
  logic      sel_c;
  logic      lut_out;
  logic      sum_out;
  logic      carry_calc;
  logic      count_next;
  logic      count_carry;
  logic      data_res;
  logic      casc_out;
  logic      reg_d;
  lcm_pkg::lcm_mode_e mode;

  assign mode = cfg_reg.mode;

  always_comb
  begin
    rd_next = 32'h0000_0000;
    if (addr_lo == lcm_pkg::ADDR_CTRL)
    begin
      rd_next[lcm_pkg::CTRL_W-1:0] = cfg_reg;
    end
    else if (addr_lo == lcm_pkg::ADDR_LUT)
    begin
      rd_next[lcm_pkg::LUT_W-1:0] = lut_reg;
    end
    else if (addr_lo == lcm_pkg::ADDR_STATUS)
    begin
      rd_next[lcm_pkg::STATUS_W-1:0] = {undef_reg, chip_rst_act, casc_out,
                                        carry_calc, lut_out, cell_q_reg};
    end
    else if (addr_lo == lcm_pkg::ADDR_INFO)
    begin
      rd_next[lcm_pkg::EMUL_COST_W-1:0] = lcm_pkg::EMUL_COST;   // see (R19)
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      HRDATA_O    <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= lcm_pkg::HRESP_OKAY;
    end
    else
    begin
      wr_pend_reg <= addr_take & HWRITE_I;
      wr_addr_reg <= addr_lo;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= lcm_pkg::HRESP_OKAY;
      if (addr_take & ~HWRITE_I)
      begin
        HRDATA_O <= rd_next;
      end
    end
  end

  // unmapped or read-only addresses drop the write
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      cfg_reg <= lcm_pkg::CTRL_RST;
      lut_reg <= lcm_pkg::LUT_RST;
    end
    else if (wr_pend_reg)
    begin
      if (wr_addr_reg == lcm_pkg::ADDR_CTRL)
      begin
        cfg_reg <= lcm_pkg::lcm_cfg_s'(HWDATA_I[lcm_pkg::CTRL_W-1:0]);
      end
      else if (wr_addr_reg == lcm_pkg::ADDR_LUT)
      begin
        lut_reg <= HWDATA_I[lcm_pkg::LUT_W-1:0];
      end
    end
  end

  // lookup datapath
  assign sel_c = cfg_reg.carry_sel ? pin.carry_in : pin.cell_input_c;        // see (R2)
  assign lut_out = lut_pick(lut_reg, {pin.cell_input_d, sel_c,
                                      pin.cell_input_b, pin.cell_input_a});  // see (R1)
  // arithmetic halves: low eight mask bits give the result, high eight the carry
  assign sum_out = lut_pick(lut_reg, {lcm_pkg::LUT_HALF_SUM, pin.carry_in,
                                      pin.cell_input_b, pin.cell_input_a});  // see (R7)
  assign carry_calc = lut_pick(lut_reg, {lcm_pkg::LUT_HALF_CARRY, pin.carry_in,
                                         pin.cell_input_b, pin.cell_input_a}); // see (R8)

  // counter: a is count enable, b is up (1) or down (0)
  assign count_next  = cell_q_reg ^ (pin.cell_input_a & pin.carry_in);       // see (R12)
  assign count_carry = pin.cell_input_a & pin.carry_in &
                       (pin.cell_input_b ? cell_q_reg : ~cell_q_reg);        // see (R15)

  always_comb
  begin
    data_res = lut_out;
    case (mode)
      lcm_pkg::MODE_NORMAL: data_res = lut_out;
      lcm_pkg::MODE_ARITH:  data_res = sum_out;
      lcm_pkg::MODE_COUNT:  data_res = count_next;
      default:              data_res = lut_out;
    endcase
  end

  // cascade stays usable in every mode
  assign casc_out = cfg_reg.casc_en ? casc_join(data_res, pin.cascade_in, cfg_reg.casc_or)
                                    : data_res;                              // see (R3) (R4) (R9)

  always_comb
  begin
    reg_d = casc_out;
    // packed register takes input d directly, only while carry-in is not a lookup input
    if (mode == lcm_pkg::MODE_NORMAL && cfg_reg.pack_en && !cfg_reg.carry_sel)
    begin
      reg_d = pin.cell_input_d;                                              // see (R5) (R6)
    end
    // clear gate after load mux, so clear wins and both beat the cascade
    if (pin.sync_load)
    begin
      reg_d = pin.cell_input_c;                                              // see (R15) (R16)
    end
    if (pin.sync_clear)
    begin
      reg_d = 1'b0;                                                          // see (R17) (R13)
    end
  end

  // chip reset only counts when the build option keeps the pin
  assign chip_rst_act = CHIP_RESET_USED & ~pin.chip_reset_n;                // see (R23)
  assign force_act    = chip_rst_act | pin.async_clear | pin.async_preset;

  // async controls act on the next system cycle without a group clock tick
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      cell_q_reg <= 1'b0;
    end
    else if (chip_rst_act)
    begin
      cell_q_reg <= cfg_reg.preset;                                          // see (R21) (R22)
    end
    else if (pin.async_clear)
    begin
      cell_q_reg <= 1'b0;                                                    // see (R18) (R26)
    end
    else if (pin.async_preset)
    begin
      cell_q_reg <= 1'b1;                                                    // see (R18)
    end
    else if (tick_en)
    begin
      cell_q_reg <= reg_d;                                                   // see (R11) (R25) (R26)
    end
  end

  // emulated register is unknown after reset until something defines it
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      undef_reg <= 1'b1;
    end
    else if (chip_rst_act)
    begin
      undef_reg <= cfg_reg.emul;                                             // see (R20)
    end
    else if (force_act || (tick_en && (pin.sync_clear || pin.sync_load)))
    begin
      undef_reg <= 1'b0;
    end
    else if (!cfg_reg.emul)
    begin
      undef_reg <= 1'b0;
    end
  end

  // outputs straight from flops; REG_O and COMB_O together give both versions
  always_ff @(posedge REF_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      COMB_O      <= 1'b0;
      REG_O       <= 1'b0;
      CARRY_O     <= 1'b0;
      CASCADE_O   <= 1'b0;
      UNDEFINED_O <= 1'b1;
    end
    else
    begin
      COMB_O      <= data_res;                                               // see (R10)
      REG_O       <= cell_q_reg;                                             // see (R10)
      CARRY_O     <= (mode == lcm_pkg::MODE_COUNT) ? count_carry : carry_calc; // see (R8)
      CASCADE_O   <= casc_out;
      UNDEFINED_O <= undef_reg & cfg_reg.emul;
    end
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_sync_clear_wins: assert property ( // see (R17)
    !force_act && tick_en && pin.sync_clear && pin.sync_load |=> cell_q_reg == 1'b0)
    else $error("sync clear did not beat load");

  a_sync_load_data: assert property ( // see (R16)
    !force_act && tick_en && !pin.sync_clear && pin.sync_load
    |=> cell_q_reg == $past(pin.cell_input_c))
    else $error("sync load did not take load data");

  a_count_step: assert property ( // see (R25)
    !force_act && tick_en && mode == lcm_pkg::MODE_COUNT && !pin.sync_clear
    && !pin.sync_load && (!cfg_reg.casc_en || (!cfg_reg.casc_or && pin.cascade_in))
    && pin.cell_input_a && pin.carry_in
    |=> cell_q_reg != $past(cell_q_reg))
    else $error("counter did not step");

  a_hold_no_enable: assert property ( // see (R24)
    !force_act && !tick_en |=> $stable(cell_q_reg))
    else $error("register changed without enabled tick");

  a_chip_reset_value: assert property ( // see (R21)
    chip_rst_act |=> cell_q_reg == $past(cfg_reg.preset))
    else $error("chip reset gave wrong value");

  a_async_clear_now: assert property ( // see (R18)
    !chip_rst_act && pin.async_clear |=> cell_q_reg == 1'b0)
    else $error("async clear ignored");

  a_arith_carry_out: assert property ( // see (R8)
    mode == lcm_pkg::MODE_ARITH ##1 $stable(cfg_reg) |-> CARRY_O == $past(carry_calc))
    else $error("arith carry out wrong");

  a_cascade_and: assert property ( // see (R4)
    cfg_reg.casc_en && !cfg_reg.casc_or && !pin.cascade_in |=> CASCADE_O == 1'b0)
    else $error("and cascade not forced low");

  a_pack_blocked: assert property ( // see (R6)
    !force_act && tick_en && mode == lcm_pkg::MODE_NORMAL && cfg_reg.carry_sel
    && !pin.sync_clear && !pin.sync_load |=> cell_q_reg == $past(casc_out))
    else $error("packed register used with carry-in");

  c_count_up: cover property (tick_en && mode == lcm_pkg::MODE_COUNT && pin.cell_input_b);
  c_count_down: cover property (tick_en && mode == lcm_pkg::MODE_COUNT && !pin.cell_input_b);
  c_clear_load: cover property (tick_en && pin.sync_clear && pin.sync_load);
  c_chip_reset: cover property (chip_rst_act && cfg_reg.preset);

endmodule // lcm_logic_cell

// file: lcm_chain_model.sv
// neighbouring cell model that drives the carry and cascade chains
`timescale 1ns/1ps

module lcm_chain_model (
  input  wire logic       clk_i,
  input  wire logic       carry_i,
  input  wire logic       cascade_i,
  input  wire logic [1:0] lag_i,
  output logic            carry_o,
  output logic            cascade_o
);
  logic [3:0] carry_pipe;
  logic [3:0] casc_pipe;

  // lower cell belongs to the same counter or is plain logic
  always_ff @(posedge clk_i)
  begin
    carry_pipe <= {carry_pipe[2:0], carry_i};
    casc_pipe  <= {casc_pipe[2:0], cascade_i};
  end

  // a slow neighbour settles one to four cycles late
  assign carry_o   = carry_pipe[lag_i];
  assign cascade_o = casc_pipe[lag_i];
endmodule // lcm_chain_model

// file: lcm_tb.sv
// self-checking testbench of the logic cell
`timescale 1ns/1ps

`define LCM_CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module testbench;
  typedef struct {logic bus; logic [31:0] v; logic [31:0] m;} lcm_note_s;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                hsel = 1'b0;
  logic [31:0]         haddr = '0;
  logic [1:0]          htrans = lcm_pkg::HTRANS_IDLE;
  logic                hwrite = 1'b0;
  logic [31:0]         hwdata = '0;
  logic [31:0]         hrdata;
  logic                hready;
  logic                hresp;
  logic [31:0]         bus_rd;
  logic [1:0]          lag = 2'h0;
  logic                carry_in;
  logic                casc_in;
  logic [4:0]          outs;
  lcm_pkg::lcm_pins_s  pins = '0;
  lcm_pkg::lcm_cfg_s   cfg = '0;
  lcm_note_s           note_q[$];
  int                  failures = 0;
  int                  compares = 0;
  logic [15:0]         mask;
  logic [3:0]          idx;
  logic                x;
  logic [1:0]          sc;

  always #2.5 clk = ~clk;

  lcm_chain_model u_chain (.clk_i(clk), .carry_i(pins.carry_in), .cascade_i(pins.cascade_in),
    .lag_i(lag), .carry_o(carry_in), .cascade_o(casc_in));

  lcm_logic_cell u_dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .CELL_INPUT_A_I(pins.cell_input_a), .CELL_INPUT_B_I(pins.cell_input_b),
    .CELL_INPUT_C_I(pins.cell_input_c), .CELL_INPUT_D_I(pins.cell_input_d),
    .CARRY_IN_I(carry_in), .CASCADE_IN_I(casc_in),
    .GROUP_CLOCK_ONE_I(pins.group_clock_one), .GROUP_CLOCK_TWO_I(pins.group_clock_two),
    .GROUP_CLOCK_ENABLE_ONE_I(pins.group_clock_enable_one),
    .GROUP_CLOCK_ENABLE_TWO_I(pins.group_clock_enable_two),
    .ASYNC_CLEAR_I(pins.async_clear), .ASYNC_PRESET_I(pins.async_preset),
    .SYNC_CLEAR_I(pins.sync_clear), .SYNC_LOAD_I(pins.sync_load),
    .CHIP_RESET_N_I(pins.chip_reset_n), .COMB_O(outs[0]), .REG_O(outs[1]),
    .CARRY_O(outs[2]), .CASCADE_O(outs[3]), .UNDEFINED_O(outs[4]));

  // monitor: pairs each settled result with the oldest note
  always @(negedge clk)
    while (note_q.size() > 0)
    begin
      lcm_note_s n;
      n = note_q.pop_front();
      `LCM_CHK((n.bus ? bus_rd : {26'h0, hresp, outs}) & n.m, n.v & n.m)
    end

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= lcm_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= lcm_pkg::HTRANS_IDLE;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    bus_rd = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    note_q.push_back('{1'b1, e, m});
  endtask

  task automatic setup();
    bus(1'b1, lcm_pkg::ADDR_LUT, {16'h0, mask});
    bus(1'b1, lcm_pkg::ADDR_CTRL, {23'h0, cfg});
  endtask

  // cell outputs {undefined, cascade, carry, reg, comb}, checked once settled
  task automatic look(input logic [4:0] e, input logic [4:0] m);
    repeat (10) @(posedge clk);
    note_q.push_back('{1'b0, {26'h0, lcm_pkg::HRESP_OKAY, e}, {26'h0, 1'b1, m}});
  endtask

  task automatic tick(input logic two);
    repeat (6) @(posedge clk);
    if (two) pins.group_clock_two <= 1'b1;
    else pins.group_clock_one <= 1'b1;
    repeat (6) @(posedge clk);
    pins.group_clock_one <= 1'b0;
    pins.group_clock_two <= 1'b0;
  endtask

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end

  initial
  begin
    void'($urandom(71344));
    pins.chip_reset_n = 1'b1;
    pins.group_clock_enable_one = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    look(5'h00, 5'h13);
    rd(lcm_pkg::ADDR_CTRL, 32'h0, 32'hffffffff);
    rd(lcm_pkg::ADDR_INFO, 32'h3, 32'hffffffff);
    bus(1'b1, lcm_pkg::ADDR_INFO, 32'hffffffff);
    rd(lcm_pkg::ADDR_INFO, 32'h3, 32'hffffffff);
    rd(8'h10, 32'h0, 32'hffffffff);
    cfg.casc_en = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      mask = 16'($urandom);
      cfg.carry_sel = i[0];
      cfg.casc_or = i[1];
      // spare mode code must behave as normal mode
      cfg.mode = i[2] ? lcm_pkg::MODE_SPARE : lcm_pkg::MODE_NORMAL;
      {pins.cell_input_a, pins.cell_input_b, pins.cell_input_c, pins.cell_input_d,
       pins.carry_in, pins.cascade_in} <= 6'($urandom);
      lag <= 2'(i);
      setup();
      @(posedge clk);
      idx = {pins.cell_input_d, cfg.carry_sel ? pins.carry_in : pins.cell_input_c,
             pins.cell_input_b, pins.cell_input_a};
      x = mask[idx];
      look({1'b0, cfg.casc_or ? (x | pins.cascade_in) : (x & pins.cascade_in), 2'b0, x},
           5'h09);
    end
    mask = 16'h0;
    cfg = '0;
    cfg.pack_en = 1'b1;
    {pins.cell_input_a, pins.cell_input_b, pins.cell_input_c, pins.cell_input_d} <= 4'h1;
    setup();
    tick(1'b0);
    look(5'h02, 5'h03);
    mask = 16'hffff;
    cfg.carry_sel = 1'b1;
    pins.cell_input_d <= 1'b0;
    setup();
    tick(1'b0);
    look(5'h03, 5'h03);
    mask = 16'he896;
    cfg = '0;
    cfg.mode = lcm_pkg::MODE_ARITH;
    cfg.casc_en = 1'b1;
    pins.cascade_in <= 1'b1;
    setup();
    for (int i = 0; i < 8; i++)
    begin
      {pins.carry_in, pins.cell_input_b, pins.cell_input_a} <= 3'(i);
      lag <= 2'(i);
      sc = 2'(i[0]) + 2'(i[1]) + 2'(i[2]);
      tick(1'b0);
      look({1'b0, sc[0], sc[1], sc[0], sc[0]}, 5'h0f);
    end
    cfg.mode = lcm_pkg::MODE_COUNT;
    setup();
    {pins.cell_input_a, pins.cell_input_c, pins.carry_in} <= 3'h0;
    pins.sync_clear <= 1'b1;
    tick(1'b0);
    look(5'h00, 5'h02);
    {pins.sync_clear, pins.sync_load, pins.cell_input_c, pins.cascade_in} <= 4'h6;
    tick(1'b0);
    look(5'h02, 5'h02);
    {pins.sync_clear, pins.sync_load, pins.cascade_in} <= 3'h7;
    tick(1'b0);
    look(5'h00, 5'h02);
    {pins.sync_clear, pins.sync_load, pins.cell_input_a, pins.cell_input_b} <= 4'h3;
    pins.carry_in <= 1'b1;
    tick(1'b0);
    look(5'h06, 5'h06);
    pins.cell_input_b <= 1'b0;
    look(5'h02, 5'h06);
    tick(1'b0);
    look(5'h04, 5'h06);
    pins.cell_input_a <= 1'b0;
    tick(1'b0);
    look(5'h00, 5'h02);
    {pins.cell_input_a, pins.group_clock_enable_one} <= 2'h2;
    tick(1'b0);
    look(5'h00, 5'h02);
    cfg.clk_sel = 1'b1;
    setup();
    pins.group_clock_enable_one <= 1'b1;
    tick(1'b1);
    look(5'h00, 5'h02);
    pins.group_clock_enable_two <= 1'b1;
    tick(1'b1);
    look(5'h02, 5'h02);
    pins.async_clear <= 1'b1;
    look(5'h00, 5'h02);
    {pins.async_clear, pins.async_preset} <= 2'h1;
    look(5'h02, 5'h02);
    cfg.preset = 1'b1;
    setup();
    {pins.async_preset, pins.async_clear, pins.chip_reset_n} <= 3'h2;
    look(5'h02, 5'h02);
    rd(lcm_pkg::ADDR_STATUS, 32'h10, 32'h10);
    {pins.async_clear, pins.chip_reset_n} <= 2'h1;
    cfg.preset = 1'b0;
    setup();
    pins.async_preset <= 1'b1;
    pins.chip_reset_n <= 1'b0;
    look(5'h00, 5'h02);
    cfg.emul = 1'b1;
    setup();
    pins.chip_reset_n <= 1'b1;
    pins.async_preset <= 1'b0;
    look(5'h10, 5'h10);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule // testbench
